// file: verilog/pdza_params.svh
// Constants of the parameter-store and zero-adjust block: defaults, indices, limits
`ifndef PDZA_PARAMS_SVH
`define PDZA_PARAMS_SVH
// Factory default communication parameters
`define PDZA_DEF_SYNC_ID 32'h00000080
`define PDZA_DEF_EMCY_ID 32'h00000081
`define PDZA_DEF_CYCLE 32'h00000000
`define PDZA_DEF_HEARTBEAT 16'h07d0
`define PDZA_DEF_ERR_BEHAV 8'h00
`define PDZA_DEF_STARTUP 32'h00000000
`define PDZA_DEF_NODE_ID 8'h01
`define PDZA_DEF_BITRATE 8'h03
`define PDZA_DEF_TERM 8'h00
`define PDZA_DEF_ERR_MASK 32'h80001d40
// Factory default application parameters
`define PDZA_DEF_APP_PROF 8'h01
`define PDZA_DEF_FUNC_MODE 8'h00
`define PDZA_DEF_MAVG 8'h00
`define PDZA_DEF_OUT_FILT 8'h00
`define PDZA_DEF_SUBRANGE 8'h00
`define PDZA_DEF_OP_PARAM 8'h02
`define PDZA_DEF_PRESET 16'h0000
// Pre-set enable bit inside an axis operating-parameter value
`define PDZA_OP_PRESET_EN_BIT 1
// Zero offset limit of two-axis sensors, 5 degrees at 0.01 degree per count
`define PDZA_ZERO_LIMIT 17'sh001f4
// Configuration write indices
`define PDZA_IDX_SYNC_ID 5'h00
`define PDZA_IDX_CYCLE 5'h01
`define PDZA_IDX_EMCY_ID 5'h02
`define PDZA_IDX_HEARTBEAT 5'h03
`define PDZA_IDX_ERR_BEHAV 5'h04
`define PDZA_IDX_STARTUP 5'h05
`define PDZA_IDX_NODE_ID 5'h06
`define PDZA_IDX_BITRATE 5'h07
`define PDZA_IDX_TERM 5'h08
`define PDZA_IDX_ERR_MASK 5'h09
`define PDZA_IDX_APP_PROF 5'h0a
`define PDZA_IDX_FUNC_MODE 5'h0b
`define PDZA_IDX_MAVG 5'h0c
`define PDZA_IDX_OUT_FILT 5'h0d
`define PDZA_IDX_SUBRANGE 5'h0e
`define PDZA_IDX_OP_X 5'h0f
`define PDZA_IDX_OP_Y 5'h10
`define PDZA_IDX_OFS_X 5'h11
`define PDZA_IDX_OFS_Y 5'h12
`define PDZA_IDX_COUNT 19
`endif

// file: verilog/pdza_pkg.sv
// Types shared by the parameter-store and zero-adjust block
package pdza_pkg;
  // Nonvolatile write request machine
  typedef enum logic [1:0] {
    PDZA_NV_IDLE = 2'b00,
    PDZA_NV_REQ = 2'b01
  } pdza_nv_state_type;
  // What a nonvolatile write covers
  typedef enum logic {
    PDZA_SCOPE_ALL = 1'b0,
    PDZA_SCOPE_OFS = 1'b1
  } pdza_scope_type;
  // Result of the last zero adjustment attempt
  typedef enum logic [1:0] {
    PDZA_ZS_NONE = 2'b00,
    PDZA_ZS_OK = 2'b01,
    PDZA_ZS_FAIL = 2'b10
  } pdza_zstat_type;
endpackage

// file: verilog/pdza_axis.sv
// One inclination axis: zero offset, pre-set value and corrected output
`timescale 1ns/1ps
`include "pdza_params.svh"
module pdza_axis #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic signed [W-1:0] meas,
  input wire logic signed [W-1:0] factory_off,
  input wire logic load_factory,
  input wire logic use_preset,
  input wire logic signed [W-1:0] preset_data,
  input wire logic commit,
  input wire logic off_wr,
  input wire logic signed [W-1:0] off_data,
  input wire logic limit_en,
  output wire logic accept,
  output wire logic signed [W-1:0] offset,
  output wire logic signed [W-1:0] preset,
  output wire logic signed [W-1:0] incl
);
  logic signed [W-1:0] offset_r;
  logic signed [W-1:0] preset_r;
  logic signed [W-1:0] incl_r;
  wire logic signed [W:0] cand;
  wire logic signed [W:0] diff;
  wire logic fits;
  wire logic in_limit;

  // Candidate offset: the reading that must become the pre-set value
  assign cand = $signed({meas[W-1], meas}) -
                (use_preset ? $signed({preset_data[W-1], preset_data}) : $signed({(W+1){1'b0}}));
  // Must fit the offset word; two-axis parts also stay within the limit
  assign fits = (cand[W] == cand[W-1]);
  assign in_limit = (cand <= `PDZA_ZERO_LIMIT) && (cand >= -`PDZA_ZERO_LIMIT);
  assign accept = fits && (!limit_en || in_limit);
  assign diff = $signed({meas[W-1], meas}) - $signed({offset_r[W-1], offset_r});

  // Offset: factory reload first, then a new adjustment replaces the old
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      offset_r <= '0;
    end else if (load_factory) begin
      offset_r <= factory_off;
    end else if (commit) begin
      offset_r <= cand[W-1:0];
    end else if (off_wr) begin
      offset_r <= off_data;
    end
  end

  // Pre-set value kept for read-back
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      preset_r <= `PDZA_DEF_PRESET;
    end else if (load_factory) begin
      preset_r <= `PDZA_DEF_PRESET;
    end else if (commit && use_preset) begin
      preset_r <= preset_data;
    end
  end

  // Output wraps rather than saturates at the word edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      incl_r <= '0;
    end else begin
      incl_r <= diff[W-1:0];
    end
  end

  assign offset = offset_r;
  assign preset = preset_r;
  assign incl = incl_r;

  a_incl_offset: assert property (@(posedge clk_sys) disable iff (!rstn)
    $stable(offset_r) |=> incl_r == W'($past(meas) - $past(offset_r)))
    else $error("axis output not reading minus offset");
  a_zero_reads: assert property (@(posedge clk_sys) disable iff (!rstn)
    (commit && !load_factory && $stable(meas)) ##1 $stable(meas)
      |=> incl_r == ($past(use_preset, 2) ? $past(preset_data, 2) : '0))
    else $error("axis did not read the pre-set value after adjustment");
endmodule // pdza_axis

// file: verilog/pdza_top.sv
// Parameter store, factory restore and zero adjustment of an inclination sensor
`timescale 1ns/1ps
`include "pdza_params.svh"
module pdza_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic two_axis_pin,
  input wire logic cmd_restore,
  input wire logic cmd_store,
  input wire logic cmd_zero,
  input wire logic [1:0] zero_axes,
  input wire logic preset_wr_x,
  input wire logic preset_wr_y,
  input wire logic signed [15:0] preset_data_x,
  input wire logic signed [15:0] preset_data_y,
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_sel,
  input wire logic [31:0] cfg_data,
  input wire logic signed [15:0] meas_x,
  input wire logic signed [15:0] meas_y,
  input wire logic signed [15:0] factory_off_x,
  input wire logic signed [15:0] factory_off_y,
  input wire logic nv_ack,
  output wire logic nv_req,
  output wire logic nv_scope,
  output wire logic [1:0] zero_status,
  output wire logic signed [15:0] incl_x,
  output wire logic signed [15:0] incl_y,
  output wire logic signed [15:0] offset_x,
  output wire logic signed [15:0] offset_y,
  output wire logic signed [15:0] preset_x,
  output wire logic signed [15:0] preset_y,
  output logic [31:0] sync_id_r,
  output logic [31:0] cycle_r,
  output logic [31:0] emcy_id_r,
  output logic [15:0] heartbeat_r,
  output logic [7:0] err_behav_r,
  output logic [31:0] startup_r,
  output logic [7:0] node_id_r,
  output logic [7:0] bitrate_r,
  output logic [7:0] term_r,
  output logic [31:0] err_mask_r,
  output logic [7:0] app_prof_r,
  output logic [7:0] func_mode_r,
  output logic [7:0] mavg_r,
  output logic [7:0] out_filt_r,
  output logic [7:0] subrange_r,
  output logic [7:0] op_x_r,
  output logic [7:0] op_y_r
);
  logic two_meta_r;
  logic two_axis_r;
  logic init_r;
  pdza_pkg::pdza_nv_state_type nv_state_r;
  pdza_pkg::pdza_nv_state_type nv_state_nxt;
  pdza_pkg::pdza_scope_type scope_r;
  pdza_pkg::pdza_scope_type scope_nxt;
  pdza_pkg::pdza_zstat_type zstat_r;
  pdza_pkg::pdza_zstat_type zstat_nxt;
  wire logic load_factory;
  wire logic [`PDZA_IDX_COUNT-1:0] cfg_dec;
  wire logic zero_x;
  wire logic zero_y;
  wire logic pre_x;
  wire logic pre_y;
  wire logic pre_en_x;
  wire logic pre_en_y;
  wire logic acc_x;
  wire logic acc_y;
  wire logic zero_try;
  wire logic pre_try;
  wire logic adj_ok;
  wire logic commit_x;
  wire logic commit_y;
  wire logic zero_nv;
  wire logic all_nv;
  wire logic any_nv;

  // Strap pin passes two flops; only the second is used
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      two_meta_r <= 1'b0;
      two_axis_r <= 1'b0;
    end else begin
      two_meta_r <= two_axis_pin;
      two_axis_r <= two_meta_r;
    end
  end

  // Offsets take their factory values once after reset, before any NV replay
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  // Restore beats every other request in the same cycle
  assign load_factory = cmd_restore || init_r;
  assign cfg_dec = (cfg_wr && !cmd_restore) ?
                   (`PDZA_IDX_COUNT'(1) << cfg_sel) : '0;

  // Adjustment requests; the zero command wins over pre-set writes
  assign zero_x = cmd_zero && zero_axes[0] && !load_factory;
  assign zero_y = cmd_zero && zero_axes[1] && !load_factory;
  assign pre_en_x = op_x_r[`PDZA_OP_PRESET_EN_BIT];
  assign pre_en_y = op_y_r[`PDZA_OP_PRESET_EN_BIT];
  assign pre_x = preset_wr_x && !cmd_zero && !load_factory;
  assign pre_y = preset_wr_y && !cmd_zero && !load_factory;
  assign zero_try = zero_x || zero_y;
  assign pre_try = pre_x || pre_y;
  // All requested axes must pass, so a two-axis request never half lands
  assign adj_ok = (!(zero_x || pre_x) || (acc_x && (zero_x || pre_en_x))) &&
                  (!(zero_y || pre_y) || (acc_y && (zero_y || pre_en_y)));
  assign commit_x = (zero_x || pre_x) && adj_ok;
  assign commit_y = (zero_y || pre_y) && adj_ok;

  // Axis instances
  pdza_axis #(.W(16)) u_axis_x (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .meas(meas_x),
    .factory_off(factory_off_x),
    .load_factory(load_factory),
    .use_preset(!cmd_zero),
    .preset_data(preset_data_x),
    .commit(commit_x),
    .off_wr(cfg_dec[`PDZA_IDX_OFS_X]),
    .off_data(cfg_data[15:0]),
    .limit_en(two_axis_r),
    .accept(acc_x),
    .offset(offset_x),
    .preset(preset_x),
    .incl(incl_x)
  );
  pdza_axis #(.W(16)) u_axis_y (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .meas(meas_y),
    .factory_off(factory_off_y),
    .load_factory(load_factory),
    .use_preset(!cmd_zero),
    .preset_data(preset_data_y),
    .commit(commit_y),
    .off_wr(cfg_dec[`PDZA_IDX_OFS_Y]),
    .off_data(cfg_data[15:0]),
    .limit_en(two_axis_r),
    .accept(acc_y),
    .offset(offset_y),
    .preset(preset_y),
    .incl(incl_y)
  );

  // Communication parameters: restore or configuration write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn || cmd_restore) begin
      sync_id_r <= `PDZA_DEF_SYNC_ID;
      cycle_r <= `PDZA_DEF_CYCLE;
      emcy_id_r <= `PDZA_DEF_EMCY_ID;
      heartbeat_r <= `PDZA_DEF_HEARTBEAT;
      err_behav_r <= `PDZA_DEF_ERR_BEHAV;
      startup_r <= `PDZA_DEF_STARTUP;
      node_id_r <= `PDZA_DEF_NODE_ID;
      bitrate_r <= `PDZA_DEF_BITRATE;
      term_r <= `PDZA_DEF_TERM;
      err_mask_r <= `PDZA_DEF_ERR_MASK;
    end else begin
      if (cfg_dec[`PDZA_IDX_SYNC_ID]) sync_id_r <= cfg_data;
      if (cfg_dec[`PDZA_IDX_CYCLE]) cycle_r <= cfg_data;
      if (cfg_dec[`PDZA_IDX_EMCY_ID]) emcy_id_r <= cfg_data;
      if (cfg_dec[`PDZA_IDX_HEARTBEAT]) heartbeat_r <= cfg_data[15:0];
      if (cfg_dec[`PDZA_IDX_ERR_BEHAV]) err_behav_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_STARTUP]) startup_r <= cfg_data;
      if (cfg_dec[`PDZA_IDX_NODE_ID]) node_id_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_BITRATE]) bitrate_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_TERM]) term_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_ERR_MASK]) err_mask_r <= cfg_data;
    end
  end

  // Application parameters: restore or configuration write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn || cmd_restore) begin
      app_prof_r <= `PDZA_DEF_APP_PROF;
      func_mode_r <= `PDZA_DEF_FUNC_MODE;
      mavg_r <= `PDZA_DEF_MAVG;
      out_filt_r <= `PDZA_DEF_OUT_FILT;
      subrange_r <= `PDZA_DEF_SUBRANGE;
      op_x_r <= `PDZA_DEF_OP_PARAM;
      op_y_r <= `PDZA_DEF_OP_PARAM;
    end else begin
      if (cfg_dec[`PDZA_IDX_APP_PROF]) app_prof_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_FUNC_MODE]) func_mode_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_MAVG]) mavg_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_OUT_FILT]) out_filt_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_SUBRANGE]) subrange_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_OP_X]) op_x_r <= cfg_data[7:0];
      if (cfg_dec[`PDZA_IDX_OP_Y]) op_y_r <= cfg_data[7:0];
    end
  end

  // Status of the last attempt; a refusal shows here and nowhere else
  assign zstat_nxt = load_factory ? pdza_pkg::PDZA_ZS_NONE :
                     !(zero_try || pre_try) ? zstat_r :
                     adj_ok ? pdza_pkg::PDZA_ZS_OK : pdza_pkg::PDZA_ZS_FAIL;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      zstat_r <= pdza_pkg::PDZA_ZS_NONE;
    end else begin
      zstat_r <= zstat_nxt;
    end
  end
  assign zero_status = zstat_r;

  // NV requests: pre-sets and configuration writes wait for the store command
  assign zero_nv = zero_try && adj_ok;
  assign all_nv = cmd_restore || cmd_store;
  assign any_nv = zero_nv || all_nv;
  // A new request in the acknowledge cycle keeps the request up; merged scopes widen
  always_comb begin
    nv_state_nxt = nv_state_r;
    scope_nxt = scope_r;
    case (nv_state_r)
      pdza_pkg::PDZA_NV_IDLE: begin
        if (any_nv) begin
          nv_state_nxt = pdza_pkg::PDZA_NV_REQ;
          scope_nxt = all_nv ? pdza_pkg::PDZA_SCOPE_ALL : pdza_pkg::PDZA_SCOPE_OFS;
        end
      end
      pdza_pkg::PDZA_NV_REQ: begin
        if (any_nv) begin
          nv_state_nxt = pdza_pkg::PDZA_NV_REQ;
          scope_nxt = (all_nv || (!nv_ack && scope_r == pdza_pkg::PDZA_SCOPE_ALL)) ?
                      pdza_pkg::PDZA_SCOPE_ALL : pdza_pkg::PDZA_SCOPE_OFS;
        end else if (nv_ack) begin
          nv_state_nxt = pdza_pkg::PDZA_NV_IDLE;
        end
      end
      default: begin
        nv_state_nxt = pdza_pkg::PDZA_NV_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nv_state_r <= pdza_pkg::PDZA_NV_IDLE;
      scope_r <= pdza_pkg::PDZA_SCOPE_ALL;
    end else begin
      nv_state_r <= nv_state_nxt;
      scope_r <= scope_nxt;
    end
  end
  assign nv_req = (nv_state_r == pdza_pkg::PDZA_NV_REQ);
  assign nv_scope = scope_r;

  // Checks of the restore values
  a_restore_comm: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_restore |=> sync_id_r == 32'h00000080 && emcy_id_r == 32'h00000081 &&
    cycle_r == 32'h0 && heartbeat_r == 16'd2000)
    else $error("communication defaults wrong after restore");
  a_restore_node: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_restore |=> node_id_r == 8'h01 && bitrate_r == 8'h03 && term_r == 8'h00)
    else $error("node, bit rate or termination wrong after restore");
  a_restore_error: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_restore |=> err_mask_r == 32'h80001d40 && err_behav_r == 8'h00 &&
    startup_r == 32'h0)
    else $error("error handling defaults wrong after restore");
  a_restore_app: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_restore |=> app_prof_r == 8'h01 && func_mode_r == 8'h00 && mavg_r == 8'h00 &&
    out_filt_r == 8'h00 && subrange_r == 8'h00)
    else $error("application defaults wrong after restore");
  a_restore_axes: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_restore |=> op_x_r == 8'h02 && op_y_r == 8'h02 && preset_x == 16'h0 &&
    preset_y == 16'h0 && offset_x == $past(factory_off_x) &&
    offset_y == $past(factory_off_y))
    else $error("axis defaults wrong after restore");

  // Check sequences for the NV request path
  sequence s_nv_cause;
    any_nv;
  endsequence
  sequence s_nv_up(logic want_ofs);
    nv_req && (nv_scope == want_ofs || nv_scope == pdza_pkg::PDZA_SCOPE_ALL);
  endsequence
  a_restore_nv: assert property (@(posedge clk_sys) disable iff (!rstn)
    (s_nv_cause and all_nv) |=> s_nv_up(1'b0) ##0 nv_scope == pdza_pkg::PDZA_SCOPE_ALL)
    else $error("restore or store did not request a full NV write");
  a_zero_nv: assert property (@(posedge clk_sys) disable iff (!rstn)
    zero_nv |=> s_nv_up(1'b1))
    else $error("accepted zero command did not request an NV write");
  a_preset_no_nv: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!nv_req && !any_nv && (pre_try || cfg_wr)) |=> !nv_req)
    else $error("pre-set or configuration write reached NV without store");
  a_refuse_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((zero_try || pre_try) && !adj_ok && !cfg_wr) |=>
      $stable(offset_x) && $stable(offset_y) && zero_status == pdza_pkg::PDZA_ZS_FAIL)
    else $error("refused adjustment changed an offset");
  a_limit_two_axis: assert property (@(posedge clk_sys) disable iff (!rstn)
    (two_axis_r && commit_x && !load_factory) |=>
      offset_x <= 16'sd500 && offset_x >= -16'sd500)
    else $error("two-axis offset beyond limit was taken");
endmodule // pdza_top

// file: tb/pdza_nv_model.sv
// Behavioural model of the nonvolatile memory controller facing the block
`timescale 1ns/1ps
module pdza_nv_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic nv_req,
  input wire logic nv_scope,
  input wire logic [7:0] ack_delay,
  output logic nv_ack,
  output int commits,
  output logic last_scope
);
  logic [7:0] wait_r;

  // Acks a pending write ack_delay cycles after it is first seen, so both prompt and slow memories are seen
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nv_ack <= 1'b0;
      wait_r <= 8'h00;
      commits <= 0;
      last_scope <= 1'b0;
    end else if (nv_ack) begin
      // Ack edge commits the image; a merged cause keeps nv_req up for another round
      nv_ack <= 1'b0;
      wait_r <= 8'h00;
      commits <= commits + 1;
      last_scope <= nv_scope;
    end else if (nv_req) begin
      if (wait_r >= ack_delay) begin
        nv_ack <= 1'b1;
      end else begin
        wait_r <= wait_r + 8'h01;
      end
    end
  end
endmodule // pdza_nv_model

// file: tb/tb_param_defaults_zero_adjust.sv
// Self-checking bench of the parameter store and zero-adjust block
`timescale 1ns/1ps
`include "pdza_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t got %h exp %h", $time, (a), (b)); end end
module tb_param_defaults_zero_adjust;
  localparam logic signed [15:0] FOFS_X = 16'h0011;
  localparam logic signed [15:0] FOFS_Y = 16'hfff0;
  logic clk_sys, rstn, two_axis_pin, cmd_restore, cmd_store, cmd_zero;
  logic preset_wr_x, preset_wr_y, cfg_wr, nv_ack, nv_req, nv_scope, last_scope;
  logic [1:0] zero_axes, zero_status;
  logic [4:0] cfg_sel;
  logic [31:0] cfg_data, sync_id_r, cycle_r, emcy_id_r, startup_r, err_mask_r;
  logic signed [15:0] preset_data_x, preset_data_y, meas_x, meas_y, incl_x, incl_y;
  logic signed [15:0] offset_x, offset_y, preset_x, preset_y;
  logic [15:0] heartbeat_r;
  logic [7:0] err_behav_r, node_id_r, bitrate_r, term_r, app_prof_r, func_mode_r;
  logic [7:0] mavg_r, out_filt_r, subrange_r, op_x_r, op_y_r, ack_delay;
  int n_errors = 0;
  int checked = 0;
  int commits;

  // Factory calibration offsets are static straps
  pdza_top i_dut (.clk_sys, .rstn, .two_axis_pin, .cmd_restore, .cmd_store, .cmd_zero,
    .zero_axes, .preset_wr_x, .preset_wr_y, .preset_data_x, .preset_data_y, .cfg_wr,
    .cfg_sel, .cfg_data, .meas_x, .meas_y, .factory_off_x(FOFS_X), .factory_off_y(FOFS_Y),
    .nv_ack, .nv_req, .nv_scope, .zero_status, .incl_x, .incl_y, .offset_x, .offset_y,
    .preset_x, .preset_y, .sync_id_r, .cycle_r, .emcy_id_r, .heartbeat_r, .err_behav_r,
    .startup_r, .node_id_r, .bitrate_r, .term_r, .err_mask_r, .app_prof_r, .func_mode_r,
    .mavg_r, .out_filt_r, .subrange_r, .op_x_r, .op_y_r);
  pdza_nv_model i_nv (.clk_sys, .rstn, .nv_req, .nv_scope, .ack_delay, .nv_ack,
    .commits, .last_scope);

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic end_sim;
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cfg(input logic [4:0] s, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_sel = s;
    cfg_data = d;
    step;
    cfg_wr = 1'b0;
  endtask

  // Waits a bounded time for the memory to take the pending write
  task automatic nv_done;
    int c0;
    c0 = commits;
    for (int i = 0; i < 20 && nv_req === 1'b1; i++) step;
    `CHK(nv_req, 1'b0)
    `CHK(commits, c0 + 1)
  endtask

  task automatic chk_defaults;
    `CHK(sync_id_r, 32'h00000080)
    `CHK(emcy_id_r, 32'h00000081)
    `CHK(cycle_r, 32'h00000000)
    `CHK(heartbeat_r, 16'h07d0)
    `CHK(node_id_r, 8'h01)
    `CHK(bitrate_r, 8'h03)
    `CHK(term_r, 8'h00)
    `CHK(err_behav_r, 8'h00)
    `CHK(startup_r, 32'h00000000)
    `CHK(err_mask_r, 32'h80001d40)
    `CHK(app_prof_r, 8'h01)
    `CHK(func_mode_r, 8'h00)
    `CHK(mavg_r, 8'h00)
    `CHK(out_filt_r, 8'h00)
    `CHK(subrange_r, 8'h00)
    `CHK(op_x_r, 8'h02)
    `CHK(op_y_r, 8'h02)
    `CHK(preset_x, 16'h0000)
    `CHK(preset_y, 16'h0000)
    `CHK(offset_x, FOFS_X)
    `CHK(offset_y, FOFS_Y)
  endtask

  // Both axes, then the 500 boundary, a refused 501, and a one-axis part
  task automatic t_zero;
    meas_x = 16'h0064;
    meas_y = 16'hffce;
    cmd_zero = 1'b1;
    zero_axes = 2'h3;
    step;
    cmd_zero = 1'b0;
    `CHK(offset_x, 16'h0064)
    `CHK(offset_y, 16'hffce)
    `CHK(zero_status, 2'h1)
    `CHK(nv_scope, 1'b1)
    step;
    `CHK(incl_x, 16'h0000)
    `CHK(incl_y, 16'h0000)
    nv_done;
    `CHK(last_scope, 1'b1)
    meas_x = 16'h01f4;
    ack_delay = 8'h05;
    cmd_zero = 1'b1;
    zero_axes = 2'h1;
    step;
    cmd_zero = 1'b0;
    `CHK(offset_x, 16'h01f4)
    `CHK(offset_y, 16'hffce)
    nv_done;
    meas_y = 16'h01f5;
    cmd_zero = 1'b1;
    zero_axes = 2'h2;
    step;
    cmd_zero = 1'b0;
    `CHK(zero_status, 2'h2)
    `CHK(offset_y, 16'hffce)
    `CHK(nv_req, 1'b0)
    two_axis_pin = 1'b0;
    meas_y = 16'h3000;
    repeat (3) step;
    cmd_zero = 1'b1;
    step;
    cmd_zero = 1'b0;
    `CHK(offset_y, 16'h3000)
    meas_y = 16'h3007;
    step;
    step;
    `CHK(incl_y, 16'h0007)
    nv_done;
    two_axis_pin = 1'b1;
    repeat (3) step;
  endtask

  // Pre-set writes, a disabled pre-set, then the master's own store
  task automatic t_preset;
    meas_x = 16'h0123;
    meas_y = 16'h0040;
    preset_data_x = 16'h0000;
    preset_data_y = 16'h0010;
    preset_wr_x = 1'b1;
    preset_wr_y = 1'b1;
    step;
    preset_wr_x = 1'b0;
    preset_wr_y = 1'b0;
    `CHK(offset_x, 16'h0123)
    `CHK(offset_y, 16'h0030)
    `CHK(preset_y, 16'h0010)
    step;
    `CHK(incl_x, 16'h0000)
    `CHK(incl_y, 16'h0010)
    `CHK(nv_req, 1'b0)
    cfg(`PDZA_IDX_OP_X, 32'h00000000);
    preset_data_x = 16'h0005;
    preset_wr_x = 1'b1;
    step;
    preset_wr_x = 1'b0;
    `CHK(zero_status, 2'h2)
    `CHK(offset_x, 16'h0123)
    cmd_store = 1'b1;
    step;
    cmd_store = 1'b0;
    `CHK(nv_req, 1'b1)
    `CHK(nv_scope, 1'b0)
    nv_done;
  endtask

  // Custom settings, then factory restore
  task automatic t_restore;
    cfg(`PDZA_IDX_NODE_ID, 32'h00000005);
    `CHK(node_id_r, 8'h05)
    `CHK(nv_req, 1'b0)
    cmd_restore = 1'b1;
    step;
    cmd_restore = 1'b0;
    chk_defaults;
    `CHK(zero_status, 2'h0)
    `CHK(nv_req, 1'b1)
    `CHK(nv_scope, 1'b0)
    nv_done;
    `CHK(last_scope, 1'b0)
  endtask

  // Main sequence: reset held 3 cycles, one init edge, then the scenarios
  initial begin
    {rstn, cmd_restore, cmd_store, cmd_zero, preset_wr_x, preset_wr_y, cfg_wr} = 7'h00;
    two_axis_pin = 1'b1;
    zero_axes = 2'h0;
    cfg_sel = 5'h00;
    cfg_data = 32'h00000000;
    {preset_data_x, preset_data_y, meas_x, meas_y} = 64'h0;
    ack_delay = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1 rstn = 1'b1;
    step;
    chk_defaults;
    t_zero;
    t_preset;
    t_restore;
    end_sim;
  end

  // Watchdog well beyond the roughly 50 cycles the scenarios need
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    end_sim;
  end
endmodule // tb_param_defaults_zero_adjust
